// File: rtl/ifd_decoder.sv
`timescale 1ns/1ps
module ifd_decoder
	import ifd_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic WORD_VALID,
	output logic WORD_READY,
	input wire logic [15:0] WORD,
	input wire logic [3:0] FORMAT,
	input wire logic SEGMENTED,
	input wire logic LONG_OPERAND,
	input wire logic DST_EXT,
	input wire logic [15:0] INSTR_ADDR,
	input wire logic [15:0] AUTO_ADDR,
	input wire logic AUTO_DOWN,
	output logic DEC_VALID,
	output logic [15:0] OPCODE_MASK,
	output logic [1:0] MODE,
	output logic [3:0] SRC_FIELD,
	output logic [3:0] DST_FIELD,
	output logic [3:0] INDEX_FIELD,
	output logic [3:0] CONDITION_FIELD,
	output logic [3:0] COUNT_FIELD,
	output logic [3:0] NUMBER_FIELD,
	output logic [7:0] DISPLACEMENT,
	output logic WORD_SIZE,
	output logic [3:0] ADDR_MODE,
	output logic [3:0] FORMAT_OUT,
	output logic [2:0] LENGTH,
	output logic SEGMENTED_LONG_OFFSET,
	output logic [31:0] ADDRESS,
	output logic [31:0] IMMEDIATE,
	output logic [15:0] REL_TARGET,
	output logic [3:0] STACK_POINTER_REG,
	output logic [15:0] AUTO_NEXT
);
	// =========================================================
	// State
	typedef struct packed {
		ifd_state_t st;
		logic [15:0] first;
		ifd_fmt_t fmt;
		logic seg;
		logic long_op;
		logic dst_ext;
		logic [15:0] pc;
		logic [1:0] addr_left;
		logic [1:0] data_left;
		logic [1:0] addr_got;
		logic [1:0] data_got;
		logic sl;
		logic [31:0] addr;
		logic [31:0] imm;
		ifd_amode_t am;
		logic [2:0] len;
	} ifd_regs_t;
	ifd_regs_t r;
	ifd_regs_t next_r;
	logic [1:0] w_mode;
	logic [3:0] w_src;
	logic w_size;
	logic [1:0] imm_words;
	logic [2:0] op_bytes;
	logic [15:0] step_out;
	ifd_fmt_t w_fmt;

	assign w_mode = WORD[MODE_HI:MODE_LO];
	assign w_src = WORD[SRC_HI:SRC_LO];
	assign w_size = WORD[SIZE_BIT];
	assign w_fmt = ifd_fmt_t'(FORMAT);
	// Immediate word count: long two, word or byte one
	assign imm_words = LONG_OPERAND ? 2'h2 : 2'h1;
	assign WORD_READY = (r.st != IFD_ST_DONE);

	// =========================================================
	// Next-state logic
	always_comb begin
		next_r = r;
		case (r.st)
			IFD_ST_FIRST: begin
				if (WORD_VALID) begin
					next_r.first = WORD;
					next_r.fmt = w_fmt;
					next_r.seg = SEGMENTED;
					next_r.long_op = LONG_OPERAND;
					next_r.dst_ext = DST_EXT;
					next_r.pc = INSTR_ADDR;
					next_r.addr = 32'h0;
					next_r.imm = 32'h0;
					next_r.addr_got = 2'h0;
					next_r.data_got = 2'h0;
					next_r.sl = 1'b0;
					next_r.addr_left = 2'h0;
					next_r.data_left = 2'h0;
					next_r.st = IFD_ST_DONE;
					next_r.len = LEN_SHORT;
					if (w_fmt != IFD_FMT1 && w_fmt != IFD_FMT2 && w_fmt != IFD_FMT6) begin
						next_r.am = (w_src == 4'h0) ? IFD_AM_REL : IFD_AM_BAS;
					end else begin
						case (w_mode)
							MODE_REG: begin
								next_r.am = IFD_AM_REG;
							end
							MODE_IM_IR: begin
								if (w_src == 4'h0) begin
									next_r.am = IFD_AM_IMM;
									next_r.data_left = imm_words;
									next_r.st = IFD_ST_DATA;
								end else begin
									next_r.am = IFD_AM_IND;
								end
							end
							MODE_DA_X: begin
								next_r.am = (w_src == 4'h0) ? IFD_AM_DIR : IFD_AM_IDX;
								next_r.addr_left = 2'h1;
								if (DST_EXT) begin
									next_r.data_left = imm_words;
								end
								next_r.st = IFD_ST_ADDR;
							end
							default: begin
								next_r.am = IFD_AM_BX;
							end
						endcase
					end
				end
			end
			IFD_ST_ADDR: begin
				if (WORD_VALID) begin
					if (r.addr_got == 2'h0) begin
						if (r.seg && WORD[SEG_LONG_BIT]) begin
							next_r.sl = 1'b1;
							next_r.addr_left = 2'h1;
							next_r.addr = {WORD, 16'h0};
						end else begin
							next_r.addr_left = 2'h0;
							next_r.addr = {16'h0, WORD};
						end
					end else begin
						next_r.addr = {r.addr[31:16], WORD};
						next_r.addr_left = 2'h0;
					end
					next_r.addr_got = r.addr_got + 2'h1;
					if (next_r.addr_left == 2'h0) begin
						next_r.st = (r.data_left != 2'h0) ? IFD_ST_DATA : IFD_ST_DONE;
					end
				end
			end
			IFD_ST_DATA: begin
				if (WORD_VALID) begin
					if (r.long_op) begin
						next_r.imm = {r.imm[15:0], WORD};
					end else if (r.first[SIZE_BIT] == SIZE_WORD) begin
						next_r.imm = {16'h0, WORD};
					end else begin
						next_r.imm = {24'h0, WORD[7:0]};
					end
					next_r.data_got = r.data_got + 2'h1;
					next_r.data_left = r.data_left - 2'h1;
					if (r.data_left == 2'h1) begin
						next_r.st = IFD_ST_DONE;
					end
				end
			end
			IFD_ST_DONE: begin
				next_r.st = IFD_ST_FIRST;
			end
			default: begin
				next_r.st = IFD_ST_FIRST;
			end
		endcase
		// Byte length: first word plus extension words
		next_r.len = 3'(LEN_SHORT + {next_r.addr_got, 1'b0} + {next_r.data_got, 1'b0});
		if (next_r.st == IFD_ST_FIRST) begin
			next_r.len = r.len;
		end
	end

	// =========================================================
	// State register
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			r <= '{st: IFD_ST_FIRST, first: 16'h0, fmt: IFD_FMT1, seg: 1'b0, long_op: 1'b0,
				dst_ext: 1'b0, pc: PC_RESET, addr_left: 2'h0, data_left: 2'h0,
				addr_got: 2'h0, data_got: 2'h0, sl: 1'b0, addr: 32'h0, imm: 32'h0,
				am: IFD_AM_REG, len: LEN_SHORT};
		end else begin
			r <= next_r;
		end
	end

	// =========================================================
	// Field outputs
	assign DEC_VALID = (r.st == IFD_ST_DONE);
	assign MODE = r.first[MODE_HI:MODE_LO];
	assign SRC_FIELD = r.first[SRC_HI:SRC_LO];
	assign DST_FIELD = r.first[DST_HI:DST_LO];
	assign INDEX_FIELD = r.first[IDX_HI:IDX_LO];
	assign CONDITION_FIELD = r.first[DST_HI:DST_LO];
	assign COUNT_FIELD = r.first[IDX_HI:IDX_LO];
	assign NUMBER_FIELD = r.first[DST_HI:DST_LO];
	assign DISPLACEMENT = r.first[DISP_HI:DISP_LO];
	assign WORD_SIZE = (r.first[SIZE_BIT] == SIZE_WORD);
	// Remaining bits are opcode
	assign OPCODE_MASK = (r.fmt == IFD_FMT1 || r.fmt == IFD_FMT2 || r.fmt == IFD_FMT6)
		? 16'h3e00 : 16'hfe00;
	assign ADDR_MODE = r.am;
	assign FORMAT_OUT = r.fmt;
	assign LENGTH = r.len;
	assign SEGMENTED_LONG_OFFSET = r.sl;
	assign ADDRESS = r.addr;
	assign IMMEDIATE = r.imm;
	// Next instruction address plus signed displacement
	assign REL_TARGET = r.pc + {13'h0, r.len}
		+ {{8{r.first[DISP_HI]}}, r.first[DISP_HI:DISP_LO]};
	assign STACK_POINTER_REG = SEGMENTED ? STACK_POINTER_SEG : STACK_POINTER_NS;
	assign op_bytes = LONG_OPERAND ? 3'h4 : (WORD_SIZE ? 3'h2 : 3'h1);
	assign AUTO_NEXT = step_out;

	ifd_addr_step u_step (
		.addr(AUTO_ADDR),
		.step(op_bytes),
		.down(AUTO_DOWN),
		.result(step_out)
	);

	// =========================================================
	// Checks
	a_reg_short: assert property (@(posedge CLK) disable iff (!RST_B)
		(r.st == IFD_ST_FIRST && WORD_VALID && w_mode == MODE_REG && w_fmt == IFD_FMT1)
		|=> (DEC_VALID && LENGTH == LEN_SHORT))
		else $error("register form not two bytes");
	a_imm_word: assert property (@(posedge CLK) disable iff (!RST_B)
		(r.st == IFD_ST_FIRST && WORD_VALID && w_fmt == IFD_FMT1 && w_mode == MODE_IM_IR
		&& w_src == 4'h0 && !LONG_OPERAND) |=> (r.st == IFD_ST_DATA && r.data_left == 2'h1))
		else $error("word immediate not one extension word");
	a_imm_len: assert property (@(posedge CLK) disable iff (!RST_B)
		(r.st == IFD_ST_DATA && WORD_VALID && r.am == IFD_AM_IMM && !r.long_op)
		|=> (DEC_VALID && LENGTH == LEN_MID))
		else $error("word immediate not four bytes");
	a_ind_noext: assert property (@(posedge CLK) disable iff (!RST_B)
		(r.st == IFD_ST_FIRST && WORD_VALID && w_fmt == IFD_FMT1 && w_mode == MODE_IM_IR
		&& w_src != 4'h0) |=> (DEC_VALID && ADDR_MODE == IFD_AM_IND))
		else $error("indirect took extension");
	a_long_len: assert property (@(posedge CLK) disable iff (!RST_B)
		(DEC_VALID && ADDR_MODE == IFD_AM_IMM && r.long_op) |-> (LENGTH == LEN_LONG))
		else $error("long immediate not six bytes");
	a_seg_long: assert property (@(posedge CLK) disable iff (!RST_B)
		(r.st == IFD_ST_ADDR && r.addr_got == 2'h0 && WORD_VALID && r.seg && WORD[SEG_LONG_BIT])
		|=> (SEGMENTED_LONG_OFFSET && r.st == IFD_ST_ADDR))
		else $error("long offset not detected");
	a_sp_select: assert property (@(posedge CLK) disable iff (!RST_B)
		STACK_POINTER_REG == (SEGMENTED ? 4'he : 4'hf))
		else $error("stack pointer wrong");
	a_byte_imm: assert property (@(posedge CLK) disable iff (!RST_B)
		(r.st == IFD_ST_DATA && WORD_VALID && !r.long_op && !r.first[SIZE_BIT])
		|=> (IMMEDIATE == {24'h0, $past(WORD[7:0])}))
		else $error("byte immediate wrong");
	a_auto_step: assert property (@(posedge CLK) disable iff (!RST_B)
		(AUTO_DOWN && !LONG_OPERAND && WORD_SIZE) |-> (AUTO_NEXT == 16'(AUTO_ADDR - 16'h2)))
		else $error("auto decrement wrong");
	a_rel_target: assert property (@(posedge CLK) disable iff (!RST_B)
		(DEC_VALID && ADDR_MODE == IFD_AM_REL && DISPLACEMENT == 8'h06)
		|-> (REL_TARGET == 16'(r.pc + 16'h8)))
		else $error("relative target wrong");
endmodule : ifd_decoder

// File: rtl/ifd_pkg.sv
// How it works
// - Every instruction belongs to one of nine basic formats fixing field layout.
// - Mode is 2 bits; counter, number, condition, index fields are 4 bits.
// - Bits outside named fields are opcode bits selecting the operation.
// - One size bit selects word or byte operands.
// - Based-indexed addressing takes index register from the 4-bit index field.
// - Relative and based offsets come from a format-dependent displacement field; the code always uses bits 7:0.
// - Extension size depends on mode, immediate size and segmentation.
// - Mode 00 with source zero is immediate; word size adds one word.
// - Byte immediate is duplicated in both halves; either half serves.
// - Long immediate takes two words, high half first.
// - Mode 00 with nonzero source is register indirect, no extension.
// - Mode 01 with source zero is a direct address from extension words.
// - Mode 01 with nonzero source is indexed: extension base plus register.
// - Immediate data follows the address words for direct or indexed destinations.
// - Relative target is next instruction address plus displacement.
// - First format lengths are 2, 4 or 6 bytes by addressing mode.
// - Stack pointer is register 15 nonsegmented, pair 14 segmented.
// - Auto-increment adds operand size in bytes to the address register.
// - Auto-decrement subtracts operand size in bytes from the address register.
// - Size bit one means word, zero means byte.
package ifd_pkg;
	// =========================================================
	// Field positions
	localparam int MODE_HI = 15;
	localparam int MODE_LO = 14;
	localparam int SIZE_BIT = 8;
	localparam int SRC_HI = 7;
	localparam int SRC_LO = 4;
	localparam int DST_HI = 3;
	localparam int DST_LO = 0;
	localparam int IDX_HI = 11;
	localparam int IDX_LO = 8;
	localparam int DISP_HI = 7;
	localparam int DISP_LO = 0;
	localparam int SEG_LONG_BIT = 15;
	// =========================================================
	// Encodings
	localparam logic [1:0] MODE_IM_IR = 2'h0;
	localparam logic [1:0] MODE_DA_X = 2'h1;
	localparam logic [1:0] MODE_REG = 2'h2;
	localparam logic SIZE_WORD = 1'h1;
	localparam logic [3:0] STACK_POINTER_NS = 4'hf;
	localparam logic [3:0] STACK_POINTER_SEG = 4'he;
	localparam logic [2:0] LEN_SHORT = 3'h2;
	localparam logic [2:0] LEN_MID = 3'h4;
	localparam logic [2:0] LEN_LONG = 3'h6;
	localparam logic [15:0] PC_RESET = 16'h0000;
	// =========================================================
	// Addressing and format types
	typedef enum logic [3:0] {
		IFD_AM_REG = 4'h0,
		IFD_AM_IMM = 4'h1,
		IFD_AM_IND = 4'h2,
		IFD_AM_DIR = 4'h3,
		IFD_AM_IDX = 4'h4,
		IFD_AM_REL = 4'h5,
		IFD_AM_BAS = 4'h6,
		IFD_AM_BX = 4'h7
	} ifd_amode_t;
	typedef enum logic [3:0] {
		IFD_FMT1 = 4'h1, IFD_FMT2 = 4'h2, IFD_FMT3 = 4'h3,
		IFD_FMT4 = 4'h4, IFD_FMT5 = 4'h5, IFD_FMT6 = 4'h6,
		IFD_FMT7 = 4'h7, IFD_FMT8 = 4'h8, IFD_FMT9 = 4'h9
	} ifd_fmt_t;
	typedef enum logic [3:0] {
		IFD_ST_FIRST = 4'b0001,
		IFD_ST_ADDR = 4'b0010,
		IFD_ST_DATA = 4'b0100,
		IFD_ST_DONE = 4'b1000
	} ifd_state_t;
endpackage : ifd_pkg

// File: rtl/ifd_addr_step.sv
`timescale 1ns/1ps
module ifd_addr_step
	import ifd_pkg::*;
(
	input wire logic [15:0] addr,
	input wire logic [2:0] step,
	input wire logic down,
	output logic [15:0] result
);
	// =========================================================
	// Address adjust by operand size
	always_comb begin
		if (down) begin
			result = addr - {13'h0000, step};
		end else begin
			result = addr + {13'h0000, step};
		end
	end
endmodule : ifd_addr_step

// File: sim/ifd_fetch_model.sv
`timescale 1ns/1ps
module ifd_fetch_model (
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic SLOW,
	input wire logic WORD_READY,
	output logic WORD_VALID,
	output logic [15:0] WORD
);
	logic [15:0] q[$];
	logic take;
	initial begin
		WORD_VALID = 1'b0;
		WORD = 16'h0000;
	end
	// =====================================
	// Handshake sampled clear of the edge
	always @(negedge CLK) begin
		take = WORD_VALID && WORD_READY;
	end
	// =====================================
	// Words in queue order, held until taken
	always @(posedge CLK) begin
		if (take) begin
			void'(q.pop_front());
		end
		#1;
		if (!WORD_VALID || take) begin
			if (RST_B && q.size() > 0 && !(SLOW && $urandom_range(0, 1) == 0)) begin
				WORD_VALID = 1'b1;
				WORD = q[0];
			end else begin
				WORD_VALID = 1'b0;
				WORD = ~WORD;
			end
		end
	end
endmodule : ifd_fetch_model

// File: sim/instruction_format_decoder_tb.sv
`timescale 1ns/1ps
module instruction_format_decoder_tb;
	import ifd_pkg::*;
	logic CLK = 1'b0;
	logic RST_B, SLOW, SEGMENTED, LONG_OPERAND, DST_EXT, AUTO_DOWN, WORD_VALID, WORD_READY;
	logic [3:0] FORMAT;
	logic [15:0] INSTR_ADDR, AUTO_ADDR, WORD;
	logic DEC_VALID, WORD_SIZE, SEGMENTED_LONG_OFFSET;
	logic [15:0] OPCODE_MASK, REL_TARGET, AUTO_NEXT;
	logic [1:0] MODE;
	logic [3:0] SRC_FIELD, DST_FIELD, INDEX_FIELD, CONDITION_FIELD, COUNT_FIELD, NUMBER_FIELD;
	logic [3:0] ADDR_MODE, FORMAT_OUT, STACK_POINTER_REG;
	logic [7:0] DISPLACEMENT;
	logic [2:0] LENGTH, fl;
	logic [31:0] ADDRESS, IMMEDIATE;
	logic [15:0] w;
	int error_cnt = 0;
	int checks = 0;
	always #12.5 CLK = ~CLK;
	ifd_fetch_model fetch (.CLK(CLK), .RST_B(RST_B), .SLOW(SLOW), .WORD_READY(WORD_READY),
		.WORD_VALID(WORD_VALID), .WORD(WORD));
	ifd_decoder uut (.CLK(CLK), .RST_B(RST_B), .WORD_VALID(WORD_VALID), .WORD_READY(WORD_READY),
		.WORD(WORD), .FORMAT(FORMAT), .SEGMENTED(SEGMENTED), .LONG_OPERAND(LONG_OPERAND),
		.DST_EXT(DST_EXT), .INSTR_ADDR(INSTR_ADDR), .AUTO_ADDR(AUTO_ADDR), .AUTO_DOWN(AUTO_DOWN),
		.DEC_VALID(DEC_VALID), .OPCODE_MASK(OPCODE_MASK), .MODE(MODE), .SRC_FIELD(SRC_FIELD),
		.DST_FIELD(DST_FIELD), .INDEX_FIELD(INDEX_FIELD), .CONDITION_FIELD(CONDITION_FIELD),
		.COUNT_FIELD(COUNT_FIELD), .NUMBER_FIELD(NUMBER_FIELD), .DISPLACEMENT(DISPLACEMENT),
		.WORD_SIZE(WORD_SIZE), .ADDR_MODE(ADDR_MODE), .FORMAT_OUT(FORMAT_OUT), .LENGTH(LENGTH),
		.SEGMENTED_LONG_OFFSET(SEGMENTED_LONG_OFFSET), .ADDRESS(ADDRESS), .IMMEDIATE(IMMEDIATE),
		.REL_TARGET(REL_TARGET), .STACK_POINTER_REG(STACK_POINTER_REG), .AUTO_NEXT(AUTO_NEXT));
	// =====================================
	// Checking and closing
	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk
	task complete_run;
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : complete_run
	// =====================================
	// Expected addressing mode from format and first word
	function automatic logic [3:0] exp_amode(input logic [3:0] fmt, input logic [15:0] w0);
		logic src_zero;
		logic fmt_mode;
		src_zero = (w0[7:4] == 4'h0);
		fmt_mode = (fmt == 4'h1 || fmt == 4'h2 || fmt == 4'h6);
		if (!fmt_mode) begin
			return src_zero ? IFD_AM_REL : IFD_AM_BAS;
		end
		if (w0[15]) begin
			return w0[14] ? IFD_AM_BX : IFD_AM_REG;
		end
		if (w0[14]) begin
			return src_zero ? IFD_AM_DIR : IFD_AM_IDX;
		end
		return src_zero ? IFD_AM_IMM : IFD_AM_IND;
	endfunction : exp_amode
	// Expected immediate value: long high first, byte from low half
	function automatic logic [31:0] exp_imm(input logic [15:0] i0, input logic [15:0] i1,
		input logic lng, input logic wsz);
		if (lng) begin
			return {i0, i1};
		end
		if (wsz) begin
			return {16'h0, i0};
		end
		return {24'h0, i0[7:0]};
	endfunction : exp_imm
	// =====================================
	// One instruction, fl = segmented, long, destination extension
	task automatic run_instr(input logic [3:0] fmt, input logic [15:0] w0, input logic [2:0] f);
		logic [15:0] a0, a1, i0, i1;
		logic [15:0] st, tgt, nxt, opm;
		logic [3:0] am;
		logic lt;
		int na, ni, n;
		@(posedge CLK);
		#1;
		FORMAT = fmt;
		{SEGMENTED, LONG_OPERAND, DST_EXT} = f;
		INSTR_ADDR = 16'($urandom);
		AUTO_ADDR = 16'($urandom);
		AUTO_DOWN = 1'($urandom);
		a0 = 16'($urandom);
		a1 = 16'($urandom);
		i0 = 16'($urandom);
		i1 = 16'($urandom);
		if (!w0[8] && !f[1]) i0 = {i0[7:0], i0[7:0]};
		am = exp_amode(fmt, w0);
		na = (am == IFD_AM_DIR || am == IFD_AM_IDX) ? ((f[2] && a0[15]) ? 2 : 1) : 0;
		ni = (am == IFD_AM_IMM || (na > 0 && f[0])) ? (f[1] ? 2 : 1) : 0;
		#1;
		fetch.q.push_back(w0);
		if (na > 0) fetch.q.push_back(a0);
		if (na > 1) fetch.q.push_back(a1);
		if (ni > 0) fetch.q.push_back(i0);
		if (ni > 1) fetch.q.push_back(i1);
		n = 0;
		do begin
			lt = WORD_VALID && WORD_READY;
			@(negedge CLK);
			n++;
		end while (DEC_VALID !== 1'b1 && n < 60);
		chk(32'(lt), 32'h1, "answer timing");
		chk(32'(DEC_VALID), 32'h1, "answer");
		chk(32'(fetch.q.size()), 32'h0, "words used");
		chk(32'(WORD_READY), 32'h0, "ready in answer");
		chk(32'(MODE), 32'(w0[15:14]), "mode");
		chk(32'({SRC_FIELD, DST_FIELD}), 32'(w0[7:0]), "source destination");
		chk(32'({INDEX_FIELD, CONDITION_FIELD}), 32'({w0[11:8], w0[3:0]}), "index cond");
		chk(32'({COUNT_FIELD, NUMBER_FIELD}), 32'({w0[11:8], w0[3:0]}), "count number");
		chk(32'(DISPLACEMENT), 32'(w0[7:0]), "displacement");
		chk(32'(WORD_SIZE), 32'(w0[8]), "size");
		chk(32'({ADDR_MODE, FORMAT_OUT}), 32'({am, fmt}), "mode and format");
		chk(32'(LENGTH), 32'(2 + 2 * (na + ni)), "length");
		opm = (am == IFD_AM_REL || am == IFD_AM_BAS) ? 16'hfe00 : 16'h3e00;
		chk(32'(OPCODE_MASK), 32'(opm), "opcode bits");
		tgt = INSTR_ADDR + 16'h2 + {{8{w0[7]}}, w0[7:0]};
		if (am == IFD_AM_REL) chk(32'(REL_TARGET), 32'(tgt), "target");
		if (na > 0) chk(ADDRESS, (na > 1) ? {a0, a1} : {16'h0, a0}, "address");
		if (na > 0) chk(32'(SEGMENTED_LONG_OFFSET), 32'(f[2] && a0[15]), "long offset");
		if (ni > 0) chk(IMMEDIATE, exp_imm(i0, i1, f[1], w0[8]), "immediate");
		chk(32'(STACK_POINTER_REG), f[2] ? 32'he : 32'hf, "stack pointer");
		st = f[1] ? 16'h4 : (w0[8] ? 16'h2 : 16'h1);
		nxt = AUTO_DOWN ? AUTO_ADDR - st : AUTO_ADDR + st;
		chk(32'(AUTO_NEXT), 32'(nxt), "step");
	endtask : run_instr
	// =====================================
	// Main sequence
	initial begin
		{RST_B, SLOW, SEGMENTED, LONG_OPERAND, DST_EXT, AUTO_DOWN} = 6'h00;
		{FORMAT, INSTR_ADDR, AUTO_ADDR} = 36'h0;
		void'($urandom(32'h879db8a3));
		repeat (5) @(posedge CLK);
		#1;
		chk(32'({DEC_VALID, WORD_READY, LENGTH}), 32'({2'b01, 3'h2}), "reset values");
		RST_B = 1'b1;
		run_instr(4'h1, 16'h0102, 3'b000);
		run_instr(4'h2, 16'h0003, 3'b000);
		run_instr(4'h1, 16'h0102, 3'b110);
		run_instr(4'h2, 16'h0132, 3'b000);
		run_instr(4'h6, 16'h4102, 3'b100);
		run_instr(4'h1, 16'h4140, 3'b000);
		run_instr(4'h6, 16'h4100, 3'b001);
		run_instr(4'h2, 16'h8132, 3'b000);
		run_instr(4'h1, 16'hc532, 3'b100);
		run_instr(4'h3, 16'h0106, 3'b000);
		run_instr(4'h9, 16'h2fa4, 3'b000);
		SLOW = 1'b1;
		repeat (120) begin
			w = 16'($urandom);
			if ($urandom_range(0, 1) == 0) w[7:4] = 4'h0;
			fl = 3'($urandom);
			if (fl[2] || fl[1] || w[15:14] != 2'b01) fl[0] = 1'b0;
			run_instr(4'($urandom_range(1, 9)), w, fl);
		end
		complete_run();
	end
	initial begin
		#(20000 * 25);
		error_cnt++;
		complete_run();
	end
endmodule : instruction_format_decoder_tb
